// >>> rtl/pmh_top.sv
// What this block does
// - With force-on set, releasing enable and hold leaves only regulator 1 on.
// - Pressing the push-button enables regulator 3 and starts wake; regulator 1 follows 2 ms after its power-good.
// - Regulator 3 power-good during wake starts the reset timer; processor reset is already low.
// - Regulator 2 turns on after regulator 3 is power-good for 4 ms.
// - Processor reset releases when the reset timer period has elapsed.
// - After button interrupt host drops enable and hold; device turns all off.
// - Each delay T lies between 88% of T minus 1 ms and 112% of T.
// - Device answers every address; offsets other than 0x00, 0x04 and 0x08 get a DECERR response.
// - Register writes move as single bytes; status reads also return the regulator enables in bits 14:8.
// - Four-bit threshold code selects 2.3 V to 3.8 V in 0.1 V steps.
// - Threshold code resets to the 3.0 V setting.
// - Low status sets below threshold, clears only about 200 mV above it.
// - No power-up until supply reaches threshold plus hysteresis.
// - Monitor mode 1 with unmasked interrupt asserts interrupt on supply drop.
// - Supply interrupt clears after supply recovers and status was read.
// - Monitor mode 0 shuts all regulators off at once on supply drop.
// - Over-temperature disables all regulators until about 20 C cooler.
// - Button status output pulls low while the push-button is held.
// - Enable drives regulators 4 to 7; hold and button drive 1 to 3.
// - Interrupt output is open-drain, low while an unmasked event pends.
`include "pmh_cfg.svh"
`default_nettype none
module pmh_top
  import pmh_pkg::*;
#(
  parameter int ADDR_W      = 8,
  parameter int MS_CYCLES   = `PMH_MS_CYCLES,
  parameter int RST_TICKS   = `PMH_RST_TIMEOUT_MS
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Control pins
  input  wire logic              ldo_group_enable_in,
  input  wire logic              core_supply_hold_in,
  input  wire logic              push_button_in_n,
  input  wire logic              reg3_power_good_in,
  input  wire logic              supply_below_fall_in,
  input  wire logic              supply_above_rise_in,
  input  wire logic              over_temp_in,
  input  wire logic              temp_recovered_in,
  output logic [3:0]             supply_threshold_sel,
  output logic [6:0]             reg_enable,
  output logic                   cpu_reset_out_n_o,
  output logic                   cpu_reset_out_n_oe,
  output logic                   button_status_out_n_o,
  output logic                   button_status_out_n_oe,
  output logic                   interrupt_out_n_o,
  output logic                   interrupt_out_n_oe
);

  // Saturating increment, used by the millisecond counter ms_r
  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    sat_inc = (v == 16'hffff) ? v : v + 16'h0001;
  endfunction

  localparam logic [15:0] RST_TICKS_W = RST_TICKS[15:0];
  localparam logic [31:0] MS_LAST     = MS_CYCLES - 1;

  // Pin synchronisers
  logic [7:0] sync1_r;
  logic [7:0] sync2_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= `PMH_SYNC_RST;
      sync2_r <= `PMH_SYNC_RST;
    end else begin
      sync1_r <= {temp_recovered_in, over_temp_in, supply_above_rise_in,
                  supply_below_fall_in, reg3_power_good_in, core_supply_hold_in,
                  ldo_group_enable_in, push_button_in_n};
      sync2_r <= sync1_r;
    end
  end

  logic pb_pressed, en_s, hold_s, pg_s, below_s, above_s, hot_s, cool_s;
  assign pb_pressed = ~sync2_r[0];
  assign en_s       = sync2_r[1];
  assign hold_s     = sync2_r[2];
  assign pg_s       = sync2_r[3];
  assign below_s    = sync2_r[4];
  assign above_s    = sync2_r[5];
  assign hot_s      = sync2_r[6];
  assign cool_s     = sync2_r[7];

  // Software-visible control bits
  logic       force_on_r, hibernate_ready_flag_r, mode_r, unmask_r;
  logic [3:0] thresh_r;

  // Threshold code goes straight to the comparator reference
  assign supply_threshold_sel = thresh_r;

  // Supply low status with hysteresis; set beats clear
  logic supply_low_r;
  always_ff @(posedge aclk) begin
    if (!aresetn)
      supply_low_r <= 1'b0;
    else if (below_s)
      supply_low_r <= 1'b1;
    else if (above_s)
      supply_low_r <= 1'b0;
  end

  // Power-up permission needs the rising threshold; lockout revokes it
  logic power_ok_r;
  always_ff @(posedge aclk) begin
    if (!aresetn)
      power_ok_r <= 1'b0;
    else if (above_s && !below_s)
      power_ok_r <= 1'b1;
    else if (supply_low_r && !mode_r)
      power_ok_r <= 1'b0;
  end

  // Thermal lock holds until the cool-down indication arrives
  logic thermal_lock_r;
  always_ff @(posedge aclk) begin
    if (!aresetn)
      thermal_lock_r <= 1'b0;
    else if (hot_s)
      thermal_lock_r <= 1'b1;
    else if (cool_s)
      thermal_lock_r <= 1'b0;
  end

  // Any of these forces every regulator off, force-on included
  logic fault;
  assign fault = thermal_lock_r | (supply_low_r & ~mode_r) | ~power_ok_r;

  // Sequencer
  pmh_state_t state_r;
  logic       keep_on;
  logic [31:0] pre_r;
  logic [15:0] ms_r;
  logic        ms_tick;
  assign keep_on = pb_pressed | hold_s | en_s;
  assign ms_tick = (pre_r == MS_LAST);

  always_ff @(posedge aclk) begin
    if (!aresetn)
      state_r <= PMH_OFF;
    else if (fault || (state_r != PMH_OFF && !keep_on))
      state_r <= PMH_OFF;
    else begin
      case (state_r)
        PMH_OFF:     if (pb_pressed) state_r <= PMH_WAIT_PG;
        PMH_WAIT_PG: if (pg_s) state_r <= PMH_TIMING;
        PMH_TIMING:  if (pg_s && ms_r >= RST_TICKS_W) state_r <= PMH_ON;
        PMH_ON:      state_r <= PMH_ON;
        default:     state_r <= PMH_OFF;
      endcase
    end
  end

  // Millisecond base restarts at power-good so delays are exact, not early
  always_ff @(posedge aclk) begin
    if (!aresetn || state_r == PMH_OFF || state_r == PMH_WAIT_PG) begin
      pre_r <= 32'h0;
      ms_r  <= 16'h0;
    end else begin
      pre_r <= ms_tick ? 32'h0 : pre_r + 32'h1;
      if (ms_tick)
        ms_r <= sat_inc(ms_r);
    end
  end

  // Regulator enables, index 0 is regulator 1
  logic active, timing;
  assign active = (state_r != PMH_OFF);
  assign timing = (state_r == PMH_TIMING) || (state_r == PMH_ON);

  always_ff @(posedge aclk) begin
    if (!aresetn)
      reg_enable <= 7'h00;
    else begin
      reg_enable[0]   <= !fault && (force_on_r ||
                         (timing && ms_r >= `PMH_REG1_DELAY_MS));
      reg_enable[1]   <= !fault && timing && ms_r >= `PMH_REG2_DELAY_MS;
      reg_enable[2]   <= !fault && active;
      reg_enable[6:3] <= {4{!fault && active && en_s}};
    end
  end

  // Processor reset held low until the time-out after power-good
  logic cpu_rst_r;
  always_ff @(posedge aclk) begin
    if (!aresetn)
      cpu_rst_r <= 1'b1;
    else
      cpu_rst_r <= (state_r != PMH_ON);
  end
  assign cpu_reset_out_n_o  = 1'b0;
  assign cpu_reset_out_n_oe = cpu_rst_r;

  // Button status follows the synchronised button
  logic pb_stat_r;
  always_ff @(posedge aclk) begin
    if (!aresetn)
      pb_stat_r <= 1'b0;
    else
      pb_stat_r <= pb_pressed;
  end
  assign button_status_out_n_o  = 1'b0;
  assign button_status_out_n_oe = pb_stat_r;

  // Register access decode
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  logic              aw_got_r, w_got_r;
  logic              do_write, rd_status;
  assign do_write = aw_got_r && w_got_r && !s_axi_bvalid;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    hit = (a == off[ADDR_W-1:0]);
  endfunction

  // Supply interrupt: set on drop, clear after recovery and a status read
  logic irq_r, status_read_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_r         <= 1'b0;
      status_read_r <= 1'b0;
    end else if (mode_r && below_s && !supply_low_r) begin
      irq_r         <= 1'b1;
      status_read_r <= 1'b0;
    end else begin
      if (rd_status && irq_r)
        status_read_r <= 1'b1;
      if (irq_r && status_read_r && !supply_low_r) begin
        irq_r         <= 1'b0;
        status_read_r <= 1'b0;
      end
    end
  end
  assign interrupt_out_n_o  = 1'b0;
  assign interrupt_out_n_oe = irq_r & unmask_r;

  // Control and threshold registers, low byte only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      force_on_r <= 1'b0;
      hibernate_ready_flag_r    <= 1'b0;
      mode_r     <= `PMH_MODE_RST;
      unmask_r   <= `PMH_UNMASK_RST;
      thresh_r   <= `PMH_THRESH_RST;
    end else if (do_write && wstrb_r[0]) begin
      if (hit(awaddr_r, `PMH_OFF_CTRL)) begin
        force_on_r <= wdata_r[`PMH_CTRL_FORCE_BIT];
        hibernate_ready_flag_r    <= wdata_r[`PMH_CTRL_HIBERNATE_READY_FLAG_BIT];
        mode_r     <= wdata_r[`PMH_CTRL_MODE_BIT];
        unmask_r   <= wdata_r[`PMH_CTRL_UNMASK_BIT];
      end
      if (hit(awaddr_r, `PMH_OFF_THRESH))
        thresh_r <= wdata_r[3:0];
    end
  end

  // Write channels are taken independently; response after both
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r     <= 1'b0;
      w_got_r      <= 1'b0;
      awaddr_r     <= '0;
      wdata_r      <= 32'h0;
      wstrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PMH_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (hit(awaddr_r, `PMH_OFF_CTRL) || hit(awaddr_r, `PMH_OFF_THRESH) ||
                         hit(awaddr_r, `PMH_OFF_STATUS)) ? `PMH_RESP_OKAY : `PMH_RESP_DECERR;
      end else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel: one cycle from address to data
  logic [7:0] rd_byte;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_status     = s_axi_arvalid && s_axi_arready && hit(s_axi_araddr, `PMH_OFF_STATUS);
  always_comb begin
    rd_byte = 8'h00;
    if (hit(s_axi_araddr, `PMH_OFF_CTRL))
      rd_byte = {4'h0, unmask_r, mode_r, hibernate_ready_flag_r, force_on_r};
    else if (hit(s_axi_araddr, `PMH_OFF_THRESH))
      rd_byte = {4'h0, thresh_r};
    else if (hit(s_axi_araddr, `PMH_OFF_STATUS))
      rd_byte = {1'b0, pb_stat_r, cpu_rst_r, pg_s, thermal_lock_r, power_ok_r,
                 irq_r, supply_low_r};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `PMH_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= hit(s_axi_araddr, `PMH_OFF_STATUS) ?
                      {17'h0, reg_enable, rd_byte} : {24'h0, rd_byte};
      s_axi_rresp  <= (hit(s_axi_araddr, `PMH_OFF_CTRL) || hit(s_axi_araddr, `PMH_OFF_THRESH)
                       || hit(s_axi_araddr, `PMH_OFF_STATUS)) ? `PMH_RESP_OKAY
                      : `PMH_RESP_DECERR;
    end else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule
`default_nettype wire

// >>> rtl/pmh_cfg.svh
`ifndef PMH_CFG_SVH
`define PMH_CFG_SVH
// Register byte offsets
`define PMH_OFF_CTRL        8'h00
`define PMH_OFF_THRESH      8'h04
`define PMH_OFF_STATUS      8'h08
// Control register fields
`define PMH_CTRL_FORCE_BIT  0
`define PMH_CTRL_HIBERNATE_READY_FLAG_BIT  1
`define PMH_CTRL_MODE_BIT   2
`define PMH_CTRL_UNMASK_BIT 3
// Reset values
`define PMH_THRESH_RST      4'h7
`define PMH_MODE_RST        1'b1
`define PMH_UNMASK_RST      1'b0
// Synchroniser reset image: bit 0 is the active-low button
`define PMH_SYNC_RST        8'h01
// Timing: clock period in ns, ms time base, sequence delays in ms
`define PMH_CLK_PERIOD_NS   4
`define PMH_MS_NS           1000000
`define PMH_MS_CYCLES       (`PMH_MS_NS / `PMH_CLK_PERIOD_NS)
`define PMH_REG1_DELAY_MS   16'h0002
`define PMH_REG2_DELAY_MS   16'h0004
`define PMH_RST_TIMEOUT_MS  64
// AXI responses
`define PMH_RESP_OKAY       2'h0
`define PMH_RESP_DECERR     2'h3
`endif

// >>> rtl/pmh_pkg.sv
`default_nettype none
package pmh_pkg;
  // Power sequencer states
  typedef enum logic [1:0] {
    PMH_OFF,
    PMH_WAIT_PG,
    PMH_TIMING,
    PMH_ON
  } pmh_state_t;
endpackage
`default_nettype wire

// >>> testbench/pmh_top_properties.sv
`default_nettype none
module pmh_top_properties #(
  parameter int MS_CYCLES = 10,
  parameter int RST_TICKS = 8
) (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       ldo_group_enable_in,
  input wire logic       push_button_in_n,
  input wire logic       reg3_power_good_in,
  input wire logic       over_temp_in,
  input wire logic [3:0] supply_threshold_sel,
  input wire logic [6:0] reg_enable,
  input wire logic       cpu_reset_out_n_oe,
  input wire logic       button_status_out_n_oe
);
  // Depths leave a few cycles for input sync and state lag
  localparam int PG_DLY  = 4 * MS_CYCLES - 4;
  localparam int RST_DLY = (RST_TICKS - 4) * MS_CYCLES - 4;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_thr_rst; $rose(aresetn) |-> supply_threshold_sel == 4'h7; endproperty
  property p_therm; over_temp_in [*6] |-> reg_enable == 7'h00; endproperty
  property p_grp; !ldo_group_enable_in [*6] |-> reg_enable[6:3] == 4'h0; endproperty
  property p_btn; !push_button_in_n [*5] |-> button_status_out_n_oe; endproperty
  property p_reg2_dly; $rose(reg_enable[1]) |-> $past(reg3_power_good_in, PG_DLY); endproperty
  property p_rst_rel;
    $fell(cpu_reset_out_n_oe) |-> reg3_power_good_in && $past(reg_enable[1], RST_DLY);
  endproperty
  property p_rst_off; !reg_enable[2] [*2] |-> cpu_reset_out_n_oe; endproperty
  property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  property p_wr_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_thr_rst: assert property (p_thr_rst) else $error("threshold reset code");
  a_therm: assert property (p_therm) else $error("rails on while hot");
  a_grp: assert property (p_grp) else $error("group rails without enable");
  a_btn: assert property (p_btn) else $error("button status not driven");
  a_reg2_dly: assert property (p_reg2_dly) else $error("rail 2 early");
  a_rst_rel: assert property (p_rst_rel) else $error("reset released early");
  a_rst_off: assert property (p_rst_off) else $error("reset free with rail 3 off");
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  c_boot: cover property ($fell(cpu_reset_out_n_oe));
  c_rail2: cover property ($rose(reg_enable[1]));
  c_hot: cover property (over_temp_in [*6]);
endmodule
bind pmh_top pmh_top_properties #(.MS_CYCLES(MS_CYCLES), .RST_TICKS(RST_TICKS))
  i_pmh_top_properties (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .ldo_group_enable_in, .push_button_in_n, .reg3_power_good_in, .over_temp_in,
  .supply_threshold_sel, .reg_enable, .cpu_reset_out_n_oe, .button_status_out_n_oe);
`default_nettype wire

// >>> testbench/pmh_host_model.sv
`default_nettype none
module pmh_host_model (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic want_en,
  input  wire logic want_hold,
  input  wire logic reg3_en,
  input  wire logic cpu_rst_oe,
  output logic      en_pin,
  output logic      hold_pin,
  output logic      pg_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Software can only drive its pins while out of reset, so a reset drops them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_pin   <= 1'b0;
      hold_pin <= 1'b0;
    end else begin
      en_pin   <= want_en & ~cpu_rst_oe;
      hold_pin <= want_hold & ~cpu_rst_oe;
    end
  end
  // Rail 3 reports good one cycle after it is switched on
  always_ff @(posedge aclk) pg_pin <= aresetn & reg3_en;
endmodule
`default_nettype wire

// >>> testbench/pmh_top_test.sv
`default_nettype none
module pmh_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        push_button_in_n = 1'b1, supply_below_fall_in = 1'b0, over_temp_in = 1'b0;
  logic        supply_above_rise_in = 1'b1, temp_recovered_in = 1'b0;
  logic        want_en = 1'b0, want_hold = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        ldo_group_enable_in, core_supply_hold_in, reg3_power_good_in;
  logic        cpu_reset_out_n_o, cpu_reset_out_n_oe, button_status_out_n_o;
  logic        button_status_out_n_oe, interrupt_out_n_o, interrupt_out_n_oe;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r, wr_r;
  logic [3:0]  s_axi_wstrb = 4'h1, supply_threshold_sel;
  logic [6:0]  reg_enable;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_d;
  int          error_cnt, n_checks, cyc;
  wire  [9:0]  st = {cpu_reset_out_n_oe, interrupt_out_n_oe, button_status_out_n_oe, reg_enable};

  pmh_top #(.MS_CYCLES(10), .RST_TICKS(8)) i_pmh_top (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ldo_group_enable_in,
    .core_supply_hold_in, .push_button_in_n, .reg3_power_good_in, .supply_below_fall_in,
    .supply_above_rise_in, .over_temp_in, .temp_recovered_in, .supply_threshold_sel,
    .reg_enable, .cpu_reset_out_n_o, .cpu_reset_out_n_oe, .button_status_out_n_o,
    .button_status_out_n_oe, .interrupt_out_n_o, .interrupt_out_n_oe);
  pmh_host_model i_pmh_host_model (.aclk, .aresetn, .want_en, .want_hold,
    .reg3_en(reg_enable[2]), .cpu_rst_oe(cpu_reset_out_n_oe), .en_pin(ldo_group_enable_in),
    .hold_pin(core_supply_hold_in), .pg_pin(reg3_power_good_in));

  // 250 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // Ceiling far above the several hundred cycles the run needs
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %0t data %h exp %h", $time, got, exp);
    end
  endtask
  // Pin compare; waits a bounded time since pins pass through synchronisers
  task automatic wt(input logic [9:0] m, input logic [9:0] v);
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (((st & m) !== v) && n < 300);
    n_checks++;
    if ((st & m) !== v) begin
      error_cnt++;
      $display("mismatch %0t pins %h exp %h", $time, st & m, v);
    end
  endtask
  // Write: address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ga, gw;
    ga = 1'b0;
    gw = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(ga && gw)) begin
      @(negedge aclk);
      ga = ga | (s_axi_awvalid & s_axi_awready);
      gw = gw | (s_axi_wvalid & s_axi_wready);
      @(posedge aclk);
      if (ga) s_axi_awvalid <= 1'b0;
      if (gw) s_axi_wvalid <= 1'b0;
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    wr_r = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    rd_d = s_axi_rdata;
    rd_r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  // Button wake: rail 3 first, reset held past rail 2, then software takes hold
  task automatic boot();
    @(posedge aclk);
    push_button_in_n <= 1'b0;
    wt(10'h080, 10'h080);
    wt(10'h004, 10'h004);
    wt(10'h202, 10'h202);
    wt(10'h207, 10'h007);
    @(posedge aclk);
    want_hold <= 1'b1;
    repeat (8) @(posedge aclk);
    push_button_in_n <= 1'b1;
    repeat (12) @(posedge aclk);
    wt(10'h087, 10'h007);
  endtask
  task automatic t_regs();
    rd(8'h00);
    chk(rd_d, 32'h0000_0004);
    rd(8'h04);
    chk(rd_d, 32'h0000_0007);
    for (int i = 0; i < 16; i++) begin
      wr(8'h04, 32'(i));
      chk({28'h0, supply_threshold_sel}, 32'(i));
    end
    wr(8'h04, 32'h0000_0007);
    chk({30'h0, wr_r}, 32'h0000_0000);
    // Byte lane 0 off: the write is answered but must leave the code alone
    s_axi_wstrb <= 4'h0;
    wr(8'h04, 32'h0000_0005);
    s_axi_wstrb <= 4'h1;
    chk({28'h0, supply_threshold_sel}, 32'h0000_0007);
    wr(8'h0c, 32'h0000_0005);
    chk({26'h0, supply_threshold_sel, wr_r}, 32'h0000_001f);
    rd(8'h0c);
    chk({rd_d[29:0], rd_r}, 32'h0000_0003);
    chk({29'h0, cpu_reset_out_n_o, button_status_out_n_o, interrupt_out_n_o}, 32'h0);
  endtask
  // Normal boot then group rails; ready flag reads 0
  task automatic t_norm();
    boot();
    @(posedge aclk);
    want_en <= 1'b1;
    wt(10'h07f, 10'h07f);
    rd(8'h00);
    chk(rd_d, 32'h0000_0004);
    rd(8'h08);
    chk(rd_d, 32'h0000_7f14);
  endtask
  // Hibernate with rail 1 forced, wake, then full shutdown
  task automatic t_hib();
    wr(8'h00, 32'h0000_0007);
    @(posedge aclk);
    want_en   <= 1'b0;
    want_hold <= 1'b0;
    wt(10'h27f, 10'h201);
    boot();
    rd(8'h00);
    chk(rd_d, 32'h0000_0007);
    wr(8'h00, 32'h0000_0004);
    wt(10'h007, 10'h007);
    @(posedge aclk);
    want_hold <= 1'b0;
    wt(10'h27f, 10'h200);
  endtask
  // Under-voltage alarm, then lockout and no restart below hysteresis
  task automatic t_uv();
    wr(8'h00, 32'h0000_000c);
    boot();
    @(posedge aclk);
    supply_above_rise_in <= 1'b0;
    supply_below_fall_in <= 1'b1;
    wt(10'h107, 10'h107);
    @(posedge aclk);
    supply_below_fall_in <= 1'b0;
    repeat (4) @(posedge aclk);
    supply_above_rise_in <= 1'b1;
    repeat (10) @(posedge aclk);
    wt(10'h100, 10'h100);
    rd(8'h08);
    chk(rd_d & 32'h1, 32'h0);
    wt(10'h100, 10'h000);
    wr(8'h00, 32'h0000_0008);
    @(posedge aclk);
    supply_above_rise_in <= 1'b0;
    supply_below_fall_in <= 1'b1;
    wt(10'h07f, 10'h000);
    @(posedge aclk);
    supply_below_fall_in <= 1'b0;
    push_button_in_n     <= 1'b0;
    repeat (20) @(posedge aclk);
    wt(10'h07f, 10'h000);
    @(posedge aclk);
    push_button_in_n     <= 1'b1;
    supply_above_rise_in <= 1'b1;
  endtask
  // Over-temperature trip blocks restart until the die has cooled
  task automatic t_therm();
    boot();
    @(posedge aclk);
    over_temp_in <= 1'b1;
    wt(10'h07f, 10'h000);
    // Keep the trip up long enough for the thermal property to fire on it
    repeat (4) @(posedge aclk);
    @(posedge aclk);
    over_temp_in     <= 1'b0;
    push_button_in_n <= 1'b0;
    repeat (20) @(posedge aclk);
    wt(10'h07f, 10'h000);
    @(posedge aclk);
    push_button_in_n  <= 1'b1;
    temp_recovered_in <= 1'b1;
    repeat (6) @(posedge aclk);
    temp_recovered_in <= 1'b0;
    boot();
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_norm();
    t_hib();
    t_uv();
    t_therm();
    stop_test();
  end
endmodule
`default_nettype wire
